// file: hw/fbpe_bus.sv
// fbpe_bus: turns one request into a flash write or read cycle on the pins
// assumes dq_in is synchronous to clk; all pin outputs are registered
module fbpe_bus (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  fbpe_bus_if.eng                        bus,
  output logic [fbpe_pkg::ADDR_W-1:0]    flash_addr,
  output logic [fbpe_pkg::DATA_W-1:0]    dq_out,
  output logic                           dq_oe,
  input  wire logic [fbpe_pkg::DATA_W-1:0] dq_in,
  output logic                           ce_n,
  output logic                           oe_n,
  output logic                           we_n
);
  import fbpe_pkg::*;

  typedef enum logic [1:0] {B_IDLE, B_WR, B_RD} fbpe_bst_e;

  fbpe_bst_e  bst_q, bst_d;
  logic [3:0] ph_q, ph_d;
  fbpe_addr_t addr_q, addr_d;
  fbpe_byte_t dq_q, dq_d, rd_q, rd_d;
  logic       oe_q, oe_d, ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, ack_q, ack_d;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    bst_d  = bst_q;
    ph_d   = ph_q + 4'h1;
    addr_d = addr_q;
    dq_d   = dq_q;
    rd_d   = rd_q;
    oe_d   = oe_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    ack_d  = 1'b0;
    case (bst_q)
      B_IDLE: begin
        ph_d = 4'h0;
        if (bus.req && !ack_q) begin
          addr_d = bus.addr;
          dq_d   = bus.wdata;
          ce_n_d = 1'b0;           // address decode style select
          oe_d   = bus.wr;
          bst_d  = bus.wr ? B_WR : B_RD;
        end
      end
      B_WR: begin
        if (ph_q == WE_FALL_PH) we_n_d = 1'b0;  // strobe only under select
        if (ph_q == WE_RISE_PH) we_n_d = 1'b1;
        if (ph_q == WR_END_PH) begin
          ce_n_d = 1'b1;
          oe_d   = 1'b0;
          ack_d  = 1'b1;
          bst_d  = B_IDLE;
        end
      end
      B_RD: begin
        if (ph_q == OE_FALL_PH) oe_n_d = 1'b0;  // read strobe on output enable
        if (ph_q == RD_SAMPLE_PH) rd_d = dq_in;
        if (ph_q == RD_END_PH) begin
          oe_n_d = 1'b1;
          ce_n_d = 1'b1;
          ack_d  = 1'b1;
          bst_d  = B_IDLE;
        end
      end
      default: bst_d = B_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bst_q  <= B_IDLE;
      ph_q   <= 4'h0;
      addr_q <= FIRST_ADDR;
      dq_q   <= CMD_READ;
      rd_q   <= CMD_READ;
      oe_q   <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ack_q  <= 1'b0;
    end else begin
      bst_q  <= bst_d;
      ph_q   <= ph_d;
      addr_q <= addr_d;
      dq_q   <= dq_d;
      rd_q   <= rd_d;
      oe_q   <= oe_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      ack_q  <= ack_d;
    end
  end

  assign flash_addr = addr_q;
  assign dq_out     = dq_q;
  assign dq_oe      = oe_q;
  assign ce_n       = ce_n_q;
  assign oe_n       = oe_n_q;
  assign we_n       = we_n_q;
  assign bus.ack    = ack_q;
  assign bus.rdata  = rd_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_we_under_ce: assert property (!we_n |-> !ce_n)
    else $error("write strobe low without chip select");
  a_oe_under_ce: assert property (!oe_n |-> (!ce_n && we_n && !dq_oe))
    else $error("output enable without select or during drive");
  a_we_pulse_len: assert property ($fell(we_n) |-> !we_n [*3] ##1 we_n)
    else $error("write strobe width wrong");
endmodule : fbpe_bus

// file: hw/fbpe_bus_if.sv
// fbpe_bus_if: one bus cycle request from the sequencer to the pin engine
// assumes req is held until ack, ack is a one-cycle pulse
interface fbpe_bus_if;
  logic                     req;
  logic                     wr;
  logic [fbpe_pkg::ADDR_W-1:0] addr;
  logic [fbpe_pkg::DATA_W-1:0] wdata;
  logic                     ack;
  logic [fbpe_pkg::DATA_W-1:0] rdata;
  modport ctl (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface : fbpe_bus_if

// file: hw/fbpe_host.sv
// fbpe_host: host sequencer that programs, erases and aborts a parallel
// command-latch flash through its pins
// assumes the flash pins are synchronous to clk and programming voltage is on
module fbpe_host #(
  parameter int                 ERASE_PULSE_US = fbpe_pkg::ERASE_PULSE_US,
  parameter int                 MAX_ER_PULSES  = fbpe_pkg::MAX_ER_PULSES,
  parameter fbpe_pkg::fbpe_addr_t LAST_ADDR    = fbpe_pkg::LAST_ADDR
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        start,
  input  wire fbpe_pkg::fbpe_op_e          op,
  input  wire logic [fbpe_pkg::ADDR_W-1:0] program_target_addr,
  input  wire logic [fbpe_pkg::DATA_W-1:0] program_target_byte,
  output logic                             busy,
  output logic                             done,
  output logic                             fail,
  output logic [fbpe_pkg::ADDR_W-1:0]      erase_check_addr,
  output logic [fbpe_pkg::ADDR_W-1:0]      flash_addr,
  output logic [fbpe_pkg::DATA_W-1:0]      dq_out,
  output logic                             dq_oe,
  input  wire logic [fbpe_pkg::DATA_W-1:0] dq_in,
  output logic                             ce_n,
  output logic                             oe_n,
  output logic                             we_n
);
  import fbpe_pkg::*;

  localparam int ERASE_CYC = ERASE_PULSE_US * CLK_MHZ;

  typedef enum logic [4:0] {
    S_IDLE, S_PG_SETUP, S_PG_WRITE, S_PG_VERIFY, S_PG_READ, S_PG_CHECK,
    S_ER_SETUP, S_ER_GO, S_EV_WRITE, S_EV_READ, S_EV_CHECK,
    S_AB_FF1, S_AB_FF2, S_RD_CMD
  } fbpe_st_e;

  fbpe_bus_if bus ();

  fbpe_st_e               st_q, st_d;
  fbpe_addr_t             addr_q, addr_d;
  fbpe_byte_t             byte_q, byte_d;
  logic [PCNT_W-1:0]      pcnt_q, pcnt_d;
  logic [ECNT_W-1:0]      ecnt_q, ecnt_d;
  logic [TMR_W-1:0]       tmr_q, tmr_d;
  logic                   era_q, era_d, fail_q, fail_d, done_q, done_d;
  fbpe_byte_t             program_check_readback;
  fbpe_byte_t             erase_check_readback;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_read(input fbpe_st_e s);
    return (s == S_PG_READ) || (s == S_EV_READ);
  endfunction : is_read

  function automatic logic is_bus(input fbpe_st_e s);
    return !(s == S_IDLE || s == S_PG_CHECK || s == S_EV_CHECK);
  endfunction : is_bus

  function automatic fbpe_byte_t cmd_of(input fbpe_st_e s, input fbpe_byte_t b);
    case (s)
      S_PG_SETUP:           return CMD_PROGRAM;
      S_PG_WRITE:           return b;
      S_PG_VERIFY:          return CMD_PVERIFY;
      S_ER_SETUP, S_ER_GO:  return CMD_ERASE;
      S_EV_WRITE:           return CMD_EVERIFY;
      S_AB_FF1, S_AB_FF2:   return CMD_RESET;
      default:              return CMD_READ;
    endcase
  endfunction : cmd_of

  ////////////////////////////////////////////////////////////////////////
  assign program_check_readback = bus.rdata;
  assign erase_check_readback   = bus.rdata;
  assign bus.req   = is_bus(st_q) && (tmr_q == '0);
  assign bus.wr    = !is_read(st_q);
  assign bus.addr  = addr_q;
  assign bus.wdata = cmd_of(st_q, byte_q);

  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    byte_d = byte_q;
    pcnt_d = pcnt_q;
    ecnt_d = ecnt_q;
    tmr_d  = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    era_d  = era_q;
    fail_d = fail_q;
    done_d = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (start) begin
          fail_d = 1'b0;
          pcnt_d = '0;
          ecnt_d = '0;
          case (op)
            OP_PROGRAM: begin
              addr_d = program_target_addr;
              byte_d = program_target_byte;
              era_d  = 1'b0;
              st_d   = S_PG_SETUP;
            end
            OP_ERASE: begin
              addr_d = FIRST_ADDR;
              byte_d = PREPROG_BYTE;
              era_d  = 1'b1;
              st_d   = S_PG_SETUP;
            end
            default: st_d = S_AB_FF1;
          endcase
        end
      end
      S_PG_SETUP: if (bus.ack) st_d = S_PG_WRITE;
      S_PG_WRITE: begin
        if (bus.ack) begin
          tmr_d  = TMR_W'(PROG_CYC);
          pcnt_d = pcnt_q + 1'b1;
          st_d   = S_PG_VERIFY;
        end
      end
      S_PG_VERIFY: begin
        if (bus.ack) begin
          tmr_d = TMR_W'(VERIFY_GAP_CYC);
          st_d  = S_PG_READ;
        end
      end
      S_PG_READ: if (bus.ack) st_d = S_PG_CHECK;
      S_PG_CHECK: begin
        if (program_check_readback == byte_q) begin
          pcnt_d = '0;
          if (!era_q) begin
            st_d = S_RD_CMD;
          end else if (addr_q == LAST_ADDR) begin
            addr_d = FIRST_ADDR;
            st_d   = S_ER_SETUP;
          end else begin
            addr_d = addr_q + 1'b1;
            st_d   = S_PG_SETUP;
          end
        end else if (pcnt_q == PCNT_W'(MAX_PG_PULSES)) begin
          fail_d = 1'b1;
          st_d   = S_RD_CMD;
        end else begin
          st_d = S_PG_SETUP;
        end
      end
      S_ER_SETUP: if (bus.ack) st_d = S_ER_GO;
      S_ER_GO: begin
        if (bus.ack) begin
          tmr_d = TMR_W'(ERASE_CYC);
          st_d  = S_EV_WRITE;
        end
      end
      S_EV_WRITE: begin
        if (bus.ack) begin
          tmr_d = TMR_W'(VERIFY_GAP_CYC);
          st_d  = S_EV_READ;
        end
      end
      S_EV_READ: if (bus.ack) st_d = S_EV_CHECK;
      S_EV_CHECK: begin
        if (erase_check_readback == ERASED_BYTE) begin
          if (addr_q == LAST_ADDR) begin
            st_d = S_RD_CMD;
          end else begin
            addr_d = addr_q + 1'b1;
            st_d   = S_EV_WRITE;
          end
        end else if (ecnt_q == ECNT_W'(MAX_ER_PULSES - 1)) begin
          fail_d = 1'b1;
          st_d   = S_RD_CMD;
        end else begin
          ecnt_d = ecnt_q + 1'b1;
          st_d   = S_ER_SETUP;
        end
      end
      S_AB_FF1: if (bus.ack) st_d = S_AB_FF2;
      S_AB_FF2: if (bus.ack) st_d = S_RD_CMD;
      S_RD_CMD: begin
        if (bus.ack) begin
          done_d = 1'b1;
          st_d   = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= S_IDLE;
      addr_q <= FIRST_ADDR;
      byte_q <= PREPROG_BYTE;
      pcnt_q <= '0;
      ecnt_q <= '0;
      tmr_q  <= '0;
      era_q  <= 1'b0;
      fail_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      byte_q <= byte_d;
      pcnt_q <= pcnt_d;
      ecnt_q <= ecnt_d;
      tmr_q  <= tmr_d;
      era_q  <= era_d;
      fail_q <= fail_d;
      done_q <= done_d;
    end
  end

  assign busy             = (st_q != S_IDLE);
  assign done             = done_q;
  assign fail             = fail_q;
  assign erase_check_addr = addr_q;

  ////////////////////////////////////////////////////////////////////////
  fbpe_bus u_bus (
    .clk        (clk),
    .resetn     (resetn),
    .bus        (bus),
    .flash_addr (flash_addr),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .dq_in      (dq_in),
    .ce_n       (ce_n),
    .oe_n       (oe_n),
    .we_n       (we_n)
  );

  ////////////////////////////////////////////////////////////////////////
  logic [TMR_W-1:0] gap_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) gap_q <= '0;
    else if (bus.ack) gap_q <= '0;
    else if (gap_q != '1) gap_q <= gap_q + 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_pulse_width: assert property ($rose(bus.req) && st_q == S_PG_VERIFY |-> gap_q >= PROG_CYC)
    else $error("program pulse shorter than required");
  a_verify_follows: assert property (st_q == S_PG_WRITE && bus.ack |=> st_q == S_PG_VERIFY)
    else $error("program pulse not followed by verify");
  a_hold_on_miss: assert property (st_q == S_PG_CHECK && program_check_readback != byte_q
    |=> $stable(addr_q))
    else $error("address advanced on a mismatch");
  a_pulse_limit: assert property (pcnt_q <= PCNT_W'(MAX_PG_PULSES))
    else $error("too many program pulses");
  a_fail_stop: assert property (st_q == S_PG_CHECK && program_check_readback != byte_q
    && pcnt_q == PCNT_W'(MAX_PG_PULSES) |=> fail_q && st_q == S_RD_CMD)
    else $error("pulse limit did not stop the sequence");
  a_ev_command: assert property (st_q == S_EV_WRITE && bus.req |-> bus.wdata == CMD_EVERIFY && bus.wr)
    else $error("erase verify write has wrong data");
  a_erase_retry: assert property (st_q == S_EV_CHECK && erase_check_readback != ERASED_BYTE && !fail_d
    |=> ecnt_q == $past(ecnt_q) + 1'b1 && st_q == S_ER_SETUP)
    else $error("failed erase verify not retried");
  a_read_return: assert property ($rose(done) |-> $past(st_q) == S_RD_CMD)
    else $error("finish without read command");
  a_abort_pair: assert property (st_q == S_AB_FF1 && bus.ack |=> st_q == S_AB_FF2 ##0 bus.wdata == CMD_RESET)
    else $error("abort is not two reset writes");
  a_setup_first: assert property ($rose(st_q == S_PG_WRITE) |-> $past(st_q) == S_PG_SETUP)
    else $error("program write without setup");

  c_prog_ok: cover property (st_q == S_PG_CHECK && !era_q && program_check_readback == byte_q);
  c_prog_fail: cover property ($rose(fail_q) && !era_q);
  c_erase_retry: cover property (st_q == S_EV_CHECK && erase_check_readback != ERASED_BYTE);
  c_abort: cover property (st_q == S_AB_FF2 && bus.ack);
endmodule : fbpe_host

// file: hw/fbpe_pkg.sv
// fbpe_pkg: constants and types of the parallel flash host sequencer
// assumes a 50 MHz clock and an 8-bit flash with a 17-bit address
package fbpe_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  typedef logic [ADDR_W-1:0] fbpe_addr_t;
  typedef logic [DATA_W-1:0] fbpe_byte_t;

  typedef enum logic [1:0] {OP_PROGRAM, OP_ERASE, OP_ABORT} fbpe_op_e;

  // command codes, data patterns and address range
  localparam fbpe_byte_t CMD_READ     = 8'h00;
  localparam fbpe_byte_t CMD_ERASE    = 8'h20;
  localparam fbpe_byte_t CMD_PROGRAM  = 8'h40;
  localparam fbpe_byte_t CMD_EVERIFY  = 8'hA0;
  localparam fbpe_byte_t CMD_PVERIFY  = 8'hC0;
  localparam fbpe_byte_t CMD_RESET    = 8'hFF;
  localparam fbpe_byte_t ERASED_BYTE  = 8'hFF;
  localparam fbpe_byte_t PREPROG_BYTE = 8'h00;
  localparam fbpe_addr_t FIRST_ADDR   = 17'h0_0000;
  localparam fbpe_addr_t LAST_ADDR    = 17'h1_FFFF;

  // timing
  localparam int CLK_MHZ        = 50;
  localparam int PROG_PULSE_US  = 10;
  localparam int PROG_CYC       = PROG_PULSE_US * CLK_MHZ;
  localparam int VERIFY_GAP_NS  = 1000;
  localparam int VERIFY_GAP_CYC = (VERIFY_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_PULSE_US = 10000;
  localparam int TMR_W          = 32;
  localparam int MAX_PG_PULSES  = 25;
  localparam int PCNT_W         = 5;
  localparam int MAX_ER_PULSES  = 1000;
  localparam int ECNT_W         = 16;

  // bus cycle phases
  localparam logic [3:0] WE_FALL_PH   = 4'h1;
  localparam logic [3:0] WE_RISE_PH   = 4'h4;
  localparam logic [3:0] WR_END_PH    = 4'h5;
  localparam logic [3:0] OE_FALL_PH   = 4'h0;
  localparam logic [3:0] RD_SAMPLE_PH = 4'h8;
  localparam logic [3:0] RD_END_PH    = 4'h9;
endpackage : fbpe_pkg

// file: verification/fbpe_flash_model.sv
// fbpe_flash_model: behavioural command-latch flash on the host pins
// assumes fbpe_host drives the pins; timing checked in ns
module fbpe_flash_model #(
  parameter int                   ERASE_PULSE_US = 2,
  parameter fbpe_pkg::fbpe_addr_t LAST_ADDR      = 17'h0_0003
) (
  input  wire fbpe_pkg::fbpe_addr_t flash_addr,
  input  wire fbpe_pkg::fbpe_byte_t dq_out,
  input  wire logic                 dq_oe,
  output fbpe_pkg::fbpe_byte_t      dq_in,
  input  wire logic                 ce_n,
  input  wire logic                 oe_n,
  input  wire logic                 we_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import fbpe_pkg::*;
  typedef enum logic [2:0] {FM_READ, FM_PARM, FM_PROG, FM_PVER, FM_EARM, FM_ERAS, FM_EVER, FM_RST1} fbpe_fm_e;
  fbpe_fm_e   mode = FM_READ;
  fbpe_addr_t lat_a, pa, ea;
  fbpe_byte_t pd, rd;
  fbpe_byte_t last_cmd = CMD_READ;
  fbpe_byte_t mem [0:LAST_ADDR];
  time        t0;
  int         prog_need = 1, erase_need = 1, last_fail = 0;
  int         pcnt, ppulse, epulse, fault_cnt, abort_cnt;
  bit         er_seen, efresh;
  ////////////////////////////////////////
  initial for (int i = 0; i <= LAST_ADDR; i++) mem[i] = ERASED_BYTE;
  assign rd    = (mode == FM_PVER) ? mem[pa] :
                 (mode == FM_EVER) ? mem[ea] : (flash_addr <= LAST_ADDR) ? mem[flash_addr] : ERASED_BYTE;
  // released bus shows the inverse, never a held value
  assign dq_in = (!ce_n && !oe_n) ? rd : ~rd;
  always @(negedge we_n) if (!ce_n) lat_a = flash_addr;
  always @(negedge oe_n) if (dq_oe) fault_cnt++;
  always @(posedge oe_n) if (mode == FM_EVER && mem[ea] !== ERASED_BYTE) last_fail = int'(ea);
  always @(posedge we_n) if (!ce_n) begin
    if (mode == FM_PARM) begin
      if (lat_a !== pa) pcnt = 0;
      pa   = lat_a;
      pd   = dq_out;
      t0   = $time;
      mode = FM_PROG;
    end else begin
      if (mode == FM_PROG) end_prog();
      if (mode == FM_ERAS) end_erase();
      do_cmd(dq_out);
    end
  end
  task automatic end_prog();
    if ($time - t0 < 10_000) fault_cnt++;
    if (dq_out !== CMD_PVERIFY) fault_cnt++;
    ppulse++;
    pcnt++;
    if (pcnt >= prog_need) mem[pa] = mem[pa] & pd;
  endtask : end_prog
  task automatic end_erase();
    if ($time - t0 < ERASE_PULSE_US * 1000) fault_cnt++;
    if (dq_out !== CMD_EVERIFY) fault_cnt++;
    epulse++;
    efresh = 1;
    for (int i = 0; i <= LAST_ADDR; i++)
      if (epulse >= erase_need + i / 2) mem[i] = ERASED_BYTE;
  endtask : end_erase
  task automatic do_cmd(input fbpe_byte_t d);
    last_cmd = d;
    case (d)
      CMD_PROGRAM: mode = FM_PARM;
      CMD_PVERIFY: mode = FM_PVER;
      CMD_ERASE: begin
        if (mode == FM_EARM) begin
          if (!er_seen) foreach (mem[i]) if (mem[i] !== PREPROG_BYTE) fault_cnt++;
          er_seen = 1;
          t0      = $time;
          mode    = FM_ERAS;
        end else begin
          mode = FM_EARM;
        end
      end
      CMD_EVERIFY: begin
        if (!er_seen) fault_cnt++;
        if (efresh && int'(lat_a) + 1 < last_fail) fault_cnt++;
        efresh = 0;
        ea     = lat_a;
        mode   = FM_EVER;
      end
      CMD_RESET: begin
        if (mode == FM_RST1) abort_cnt++;
        mode = (mode == FM_RST1) ? FM_READ : FM_RST1;
      end
      CMD_READ: begin
        mode      = FM_READ;
        pcnt      = 0;
        er_seen   = 0;
        last_fail = 0;
      end
      default: fault_cnt++;
    endcase
  endtask : do_cmd
endmodule : fbpe_flash_model

// file: verification/tb_flash_byte_program_erase_cmds.sv
// tb_flash_byte_program_erase_cmds: self-checking bench for fbpe_host
// assumes fbpe_flash_model on the flash pins, 50 MHz clock
module tb_flash_byte_program_erase_cmds;
  timeunit 1ns;
  timeprecision 1ns;
  import fbpe_pkg::*;
  localparam int         EUS  = 2;
  localparam int         MAXE = 3;
  localparam fbpe_addr_t LAST = 17'h0_0003;
  logic       clk    = 1'h0;
  logic       resetn = 1'h0;
  logic       start  = 1'h0;
  fbpe_op_e   op     = OP_PROGRAM;
  fbpe_addr_t pta    = '0;
  fbpe_byte_t ptb    = '0;
  logic       busy, done, fail, dq_oe, ce_n, oe_n, we_n;
  fbpe_addr_t eca, fa;
  fbpe_byte_t dqo, dqi;
  int         err_count = 0;
  int         cmp_count = 0;
  ////////////////////////////////////////
  fbpe_host #(.ERASE_PULSE_US(EUS), .MAX_ER_PULSES(MAXE), .LAST_ADDR(LAST)) dut (
    .clk(clk), .resetn(resetn), .start(start), .op(op), .program_target_addr(pta),
    .program_target_byte(ptb), .busy(busy), .done(done), .fail(fail), .erase_check_addr(eca),
    .flash_addr(fa), .dq_out(dqo), .dq_oe(dq_oe), .dq_in(dqi), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
  fbpe_flash_model #(.ERASE_PULSE_US(EUS), .LAST_ADDR(LAST)) flash (
    .flash_addr(fa), .dq_out(dqo), .dq_oe(dq_oe), .dq_in(dqi), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
  initial forever #10 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // one operation; a start held on while busy must be ignored
  task automatic run(input fbpe_op_e o, input fbpe_addr_t a, input fbpe_byte_t b);
    int n;
    @(negedge clk);
    op    = o;
    pta   = a;
    ptb   = b;
    start = 1'h1;
    @(negedge clk);
    op    = OP_ERASE;
    chk("busy after start", 1, busy);
    @(negedge clk);
    start = 1'h0;
    n     = 0;
    while (done !== 1'h1 && n < 40_000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40_000) begin
      err_count++;
      $display("CHECK FAILED done expected 1 seen 0");
      tally_and_finish();
    end
    chk("busy at done", 0, busy);
    @(negedge clk);
    chk("done width", 0, done);
    chk("busy after done", 0, busy);
    chk("final command", CMD_READ, flash.last_cmd);
  endtask : run
  task automatic t_program(input fbpe_addr_t a, input fbpe_byte_t b, input int need, input int np,
                           input logic fl);
    int         p0;
    fbpe_byte_t old;
    p0              = flash.ppulse;
    old             = flash.mem[a];
    flash.prog_need = need;
    run(OP_PROGRAM, a, b);
    chk("program fail", fl, fail);
    chk("program pulses", np, flash.ppulse - p0);
    chk("programmed byte", fl ? old : old & b, flash.mem[a]);
  endtask : t_program
  task automatic t_abort(input fbpe_op_e o);
    int         a0;
    fbpe_byte_t m0;
    a0 = flash.abort_cnt;
    m0 = flash.mem[2];
    run(o, 17'h0_0002, 8'h00);
    chk("abort count", a0 + 1, flash.abort_cnt);
    chk("array kept", m0, flash.mem[2]);
    chk("abort fail", 0, fail);
  endtask : t_abort
  task automatic t_erase(input int need, input int np, input logic fl);
    int e0, p0;
    e0               = flash.epulse;
    p0               = flash.ppulse;
    flash.prog_need  = 1;
    flash.erase_need = need;
    for (int i = 0; i <= LAST; i++) flash.mem[i] = 8'hA5;
    run(OP_ERASE, '0, '0);
    chk("preprogram pulses", LAST + 1, flash.ppulse - p0);
    chk("erase pulses", np, flash.epulse - e0);
    chk("erase fail", fl, fail);
    if (fl) chk("failing address", 0, eca);
    for (int i = 0; i <= LAST; i++) chk("erased byte", fl ? 8'h00 : 8'hFF, flash.mem[i]);
  endtask : t_erase
  initial begin
    repeat (3) @(negedge clk);
    chk("reset ce_n", 1, ce_n);
    chk("reset we_n", 1, we_n);
    chk("reset oe_n", 1, oe_n);
    chk("reset dq_oe", 0, dq_oe);
    chk("reset busy", 0, busy);
    resetn = 1'h1;
    t_program(17'h0_0002, 8'h5A, 1, 1, 1'h0);
    t_program(17'h0_0001, 8'hC3, 3, 3, 1'h0);
    t_program(17'h0_0003, 8'h0F, 30, 25, 1'h1);
    t_abort(OP_ABORT);
    t_abort(fbpe_op_e'(2'h3));
    t_erase(1, 2, 1'h0);
    t_erase(9, MAXE, 1'h1);
    chk("protocol faults", 0, flash.fault_cnt);
    tally_and_finish();
  end
endmodule : tb_flash_byte_program_erase_cmds
